// File: design/lrac_top.v
// receive delay-line aligner with serial configuration port
`timescale 1ns/10ps
`include "lrac_map.vh"
module lrac_top (
  // clock, reset, enable
  input  wire       CLK_SYS_IN,
  input  wire       RSTN_IN,
  input  wire       CE_IN,
  // serial configuration port
  input  wire       SPI_CS_N_IN,
  input  wire       SPI_SCLK_IN,
  input  wire       SPI_SDI_IN,
  output reg        SPI_SDO_OUT,
  output reg        SPI_SDO_OE_N_OUT,
  // link side
  input  wire       SRC_SYNC_DCLK_IN,
  input  wire       PD_EARLY_IN,
  input  wire       PD_LATE_IN,
  // delay line settings and interrupt
  output reg  [9:0] DATA_DELAY_OUT,
  output reg  [9:0] CLK_DELAY_OUT,
  output reg  [3:0] WINDOW_OUT,
  output reg        IRQ_OUT
);
  localparam ST_IDLE   = 2'b00;
  localparam ST_SEARCH = 2'b01;
  localparam ST_TRACK  = 2'b10;
  localparam ST_LOST   = 2'b11;

  function [9:0] clamp_tap;
    input [9:0] v;
    begin
      clamp_tap = (v > `LRAC_TAP_MAX) ? `LRAC_TAP_MAX : v;
    end
  endfunction

  // single tap steps; callers guard both ends of the delay line
  function [9:0] tap_up;
    input [9:0] v;
    begin
      tap_up = v + 10'h001;
    end
  endfunction

  function [9:0] tap_down;
    input [9:0] v;
    begin
      tap_down = v - 10'h001;
    end
  endfunction

  // configuration registers
  reg  [7:0] clk_gate_r;
  reg  [1:0] irq_en_r;
  reg  [1:0] irq_stat_r;
  reg  [7:0] ctrl_r;
  reg        flag_clr_prev_r;
  reg  [7:0] ddly_lo_r;
  reg  [7:0] ddly_hi_r;
  reg  [7:0] cdly_lo_win_r;
  reg  [7:0] cdly_hi_r;
  // aligner state
  reg  [1:0] state_r;
  reg  [9:0] tap_r;
  reg  [9:0] act_tap_r;
  reg  [3:0] stable_r;
  reg        locked_r;
  reg        lost_r;
  reg        tracking_r;
  // synchronisers
  reg  [1:0] cs_s_r;
  reg  [2:0] sck_s_r;
  reg  [1:0] sdi_s_r;
  reg  [2:0] dclk_s_r;
  reg  [1:0] early_s_r;
  reg  [1:0] late_s_r;
  // serial engine
  reg  [4:0] bit_cnt_r;
  reg  [15:0] sh_in_r;
  reg  [7:0] sh_out_r;
  reg        rd_r;

  wire       sck_rise   = sck_s_r[1] & ~sck_s_r[2];
  wire       sck_fall   = ~sck_s_r[1] & sck_s_r[2];
  wire       cs_act     = ~cs_s_r[1];
  wire       dclk_rise  = dclk_s_r[1] & ~dclk_s_r[2];
  wire       align_en   = ctrl_r[`LRAC_B_ENABLE];
  wire       relock_en  = ctrl_r[`LRAC_B_RELOCK];
  wire       gate_on    = clk_gate_r[`LRAC_B_GATE];
  wire [9:0] dstart     = clamp_tap({ddly_hi_r, ddly_lo_r[7:6]});
  wire [9:0] cstart     = clamp_tap({cdly_hi_r[5:0], cdly_lo_win_r[7:4]});
  wire [15:0] sh_in_nxt = {sh_in_r[14:0], sdi_s_r[1]};
  wire       wr_done    = sck_rise && cs_act && (bit_cnt_r == `LRAC_SPI_BITS - 5'h01) && !rd_r;
  // fifteen bits are in at the last rise: r/w on top, then the address
  wire [6:0] wr_addr    = sh_in_r[13:7];
  wire [7:0] wr_data    = sh_in_nxt[7:0];
  wire       flag_clear = wr_done && (wr_addr == `LRAC_A_CTRL) && flag_clr_prev_r &&
                          !wr_data[`LRAC_B_FLAG_CLR];
  // status reads only select values, never change state
  function [7:0] read_mux;
    input [6:0] a;
    begin
      case (a)
        `LRAC_A_CLK_GATE:    read_mux = clk_gate_r;
        `LRAC_A_IRQ_STAT:    read_mux = {6'h00, irq_stat_r};
        `LRAC_A_CTRL:        read_mux = {6'h00, ctrl_r[1:0]};
        `LRAC_A_DDLY_LO:     read_mux = ddly_lo_r;
        `LRAC_A_DDLY_HI:     read_mux = ddly_hi_r;
        `LRAC_A_CDLY_LO_WIN: read_mux = cdly_lo_win_r;
        `LRAC_A_CDLY_HI:     read_mux = cdly_hi_r;
        `LRAC_A_DACT_LO:     read_mux = {act_tap_r[1:0], 6'h00};
        `LRAC_A_DACT_HI:     read_mux = act_tap_r[9:2];
        `LRAC_A_CACT_LO:     read_mux = {act_tap_r[1:0], 6'h00};
        `LRAC_A_CACT_HI:     read_mux = act_tap_r[9:2];
        `LRAC_A_STATUS:      read_mux = {4'h0, tracking_r, (state_r == ST_SEARCH),
                                         lost_r, locked_r};
        default:             read_mux = 8'h00;
      endcase
    end
  endfunction

  // two-stage synchronisers; only stage two and later feed logic
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cs_s_r    <= 2'h3;
      sck_s_r   <= 3'h0;
      sdi_s_r   <= 2'h0;
      dclk_s_r  <= 3'h0;
      early_s_r <= 2'h0;
      late_s_r  <= 2'h0;
    end else if (CE_IN) begin
      cs_s_r    <= {cs_s_r[0], SPI_CS_N_IN};
      sck_s_r   <= {sck_s_r[1:0], SPI_SCLK_IN};
      sdi_s_r   <= {sdi_s_r[0], SPI_SDI_IN};
      dclk_s_r  <= {dclk_s_r[1:0], SRC_SYNC_DCLK_IN};
      early_s_r <= {early_s_r[0], PD_EARLY_IN};
      late_s_r  <= {late_s_r[0], PD_LATE_IN};
    end
  end

  // serial engine: r/w bit, 7-bit address, 8 data bits, msb first
  // sclk is oversampled, so it must stay well below a quarter of the system clock
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      bit_cnt_r        <= 5'h00;
      sh_in_r          <= 16'h0000;
      sh_out_r         <= 8'h00;
      rd_r             <= 1'b0;
      SPI_SDO_OUT      <= 1'b0;
      SPI_SDO_OE_N_OUT <= 1'b1;
    end else if (CE_IN) begin
      if (!cs_act) begin
        bit_cnt_r        <= 5'h00;
        rd_r             <= 1'b0;
        SPI_SDO_OE_N_OUT <= 1'b1;
      end else begin
        if (sck_rise) begin
          sh_in_r   <= sh_in_nxt;
          bit_cnt_r <= (bit_cnt_r == `LRAC_SPI_BITS - 5'h01) ? 5'h00 : bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'h00)
            rd_r <= sdi_s_r[1];
          if (bit_cnt_r == `LRAC_SPI_CMD_BITS - 5'h01)
            sh_out_r <= read_mux(sh_in_nxt[6:0]);
        end
        if (sck_fall && rd_r && (bit_cnt_r >= `LRAC_SPI_CMD_BITS)) begin
          SPI_SDO_OUT      <= sh_out_r[7];
          sh_out_r         <= {sh_out_r[6:0], 1'b0};
          SPI_SDO_OE_N_OUT <= 1'b0;
        end else if (sck_fall && (bit_cnt_r == 5'h00)) begin
          SPI_SDO_OE_N_OUT <= 1'b1;
        end
      end
    end
  end

  // register writes
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      clk_gate_r      <= `LRAC_R_CLK_GATE;
      irq_en_r        <= 2'h0;
      ctrl_r          <= `LRAC_R_CTRL;
      flag_clr_prev_r <= 1'b0;
      ddly_lo_r       <= `LRAC_R_DDLY_LO;
      ddly_hi_r       <= `LRAC_R_DDLY_HI;
      cdly_lo_win_r   <= `LRAC_R_CDLY_LO_WIN;
      cdly_hi_r       <= `LRAC_R_CDLY_HI;
    end else if (CE_IN && wr_done) begin
      case (wr_addr)
        `LRAC_A_CLK_GATE:    clk_gate_r    <= wr_data;
        `LRAC_A_IRQ_EN:      irq_en_r      <= wr_data[1:0];
        `LRAC_A_CTRL: begin
          ctrl_r          <= {6'h00, wr_data[1:0]};
          flag_clr_prev_r <= wr_data[`LRAC_B_FLAG_CLR];
        end
        `LRAC_A_DDLY_LO:     ddly_lo_r     <= wr_data;
        `LRAC_A_DDLY_HI:     ddly_hi_r     <= wr_data;
        `LRAC_A_CDLY_LO_WIN: cdly_lo_win_r <= wr_data;
        `LRAC_A_CDLY_HI:     cdly_hi_r     <= wr_data;
        default: ;
      endcase
    end
  end

  // aligner: walk the tap on each rising data clock edge until the detector rests
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r    <= ST_IDLE;
      tap_r      <= 10'h000;
      act_tap_r  <= 10'h000;
      stable_r   <= 4'h0;
      locked_r   <= 1'b0;
      lost_r     <= 1'b0;
      tracking_r <= 1'b0;
    end else if (CE_IN) begin
      if (flag_clear)
        lost_r <= 1'b0;
      if (!align_en) begin
        state_r    <= ST_IDLE;
        locked_r   <= 1'b0;
        tracking_r <= 1'b0;
        stable_r   <= 4'h0;
      end else if (gate_on) begin
        case (state_r)
          ST_IDLE: begin
            state_r <= ST_SEARCH;
            tap_r   <= cstart;
          end
          ST_SEARCH: if (dclk_rise) begin
            if (early_s_r[1] && !late_s_r[1] && tap_r < `LRAC_TAP_MAX) begin
              tap_r    <= tap_up(tap_r);
              stable_r <= 4'h0;
            end else if (late_s_r[1] && !early_s_r[1] && tap_r != 10'h000) begin
              tap_r    <= tap_down(tap_r);
              stable_r <= 4'h0;
            end else if (stable_r == `LRAC_STABLE_EDGES) begin
              state_r    <= ST_TRACK;
              locked_r   <= 1'b1;
              tracking_r <= 1'b1;
              act_tap_r  <= tap_r;
            end else begin
              stable_r <= stable_r + 4'h1;
            end
          end
          ST_TRACK: if (dclk_rise) begin
            if ((early_s_r[1] && late_s_r[1]) ||
                (early_s_r[1] && tap_r == `LRAC_TAP_MAX) ||
                (late_s_r[1] && tap_r == 10'h000)) begin
              lost_r     <= 1'b1;
              locked_r   <= 1'b0;
              tracking_r <= 1'b0;
              stable_r   <= 4'h0;
              if (relock_en) begin
                state_r <= ST_SEARCH;
                tap_r   <= cstart;
              end else begin
                state_r <= ST_LOST;
              end
            end else if (early_s_r[1]) begin
              tap_r     <= tap_up(tap_r);
              act_tap_r <= tap_up(tap_r);
            end else if (late_s_r[1]) begin
              tap_r     <= tap_down(tap_r);
              act_tap_r <= tap_down(tap_r);
            end
          end
          ST_LOST: if (relock_en) begin
            state_r <= ST_SEARCH;
            tap_r   <= cstart;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // interrupt status: the enable-low clear wins over set
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      irq_stat_r <= 2'h0;
      IRQ_OUT    <= 1'b0;
    end else if (CE_IN) begin
      irq_stat_r[`LRAC_B_LOCK_IRQ] <= irq_en_r[`LRAC_B_LOCK_IRQ] &
                                      (irq_stat_r[`LRAC_B_LOCK_IRQ] | locked_r);
      irq_stat_r[`LRAC_B_LOST_IRQ] <= irq_en_r[`LRAC_B_LOST_IRQ] &
                                      (irq_stat_r[`LRAC_B_LOST_IRQ] | lost_r);
      IRQ_OUT <= |irq_stat_r;
    end
  end

  // delay line drive: fixed values while disabled, search tap while enabled
  always @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      DATA_DELAY_OUT <= 10'h000;
      CLK_DELAY_OUT  <= 10'h000;
      WINDOW_OUT     <= 4'h0;
    end else if (CE_IN) begin
      DATA_DELAY_OUT <= align_en ? tap_r : dstart;
      CLK_DELAY_OUT  <= align_en ? tap_r : cstart;
      WINDOW_OUT     <= cdly_lo_win_r[3:0];
    end
  end
endmodule // lrac_top

// File: design/lrac_map.vh
// register map, field positions, reset values and timing constants for the receive aligner
// Summary of operation
// - writing flag clear bit 2 as one then zero clears the lost-lock flag (status bit 1).
// - with auto-relock set, lost lock raises interrupt and restarts search automatically.
// - control bit 0 enables the aligner; reset leaves it disabled.
// - data delay is fixed data delay when disabled; search starts from the clock-input delay when enabled.
// - clock-input delay split over two registers; start value or fixed delay.
// - four-bit window sets spacing between early and late clock samples.
// - chosen data and clock delays read back at 0x19 through 0x1c.
// - reported data and clock-input delays are equal after alignment.
// - status bit 3 shows tracking established.
// - status bit 2 shows edge search machine active.
// - status bit 1 shows lock has been lost.
// - status bit 0 shows aligner locked.
// - write-only enables gate lock and lost interrupt bits; zero clears them.
// - clock gate bit, reset one, stops the aligner clock when cleared.
`ifndef LRAC_MAP_VH
`define LRAC_MAP_VH
`define LRAC_A_CLK_GATE      7'h02
`define LRAC_A_IRQ_EN        7'h03
`define LRAC_A_IRQ_STAT      7'h04
`define LRAC_A_CTRL          7'h10
`define LRAC_A_DDLY_LO       7'h11
`define LRAC_A_DDLY_HI       7'h12
`define LRAC_A_CDLY_LO_WIN   7'h13
`define LRAC_A_CDLY_HI       7'h14
`define LRAC_A_DACT_LO       7'h19
`define LRAC_A_DACT_HI       7'h1a
`define LRAC_A_CACT_LO       7'h1b
`define LRAC_A_CACT_HI       7'h1c
`define LRAC_A_STATUS        7'h21
`define LRAC_B_GATE          1
`define LRAC_B_LOCK_IRQ      0
`define LRAC_B_LOST_IRQ      1
`define LRAC_B_ENABLE        0
`define LRAC_B_RELOCK        1
`define LRAC_B_FLAG_CLR      2
`define LRAC_R_CLK_GATE      8'h02
`define LRAC_R_CTRL          8'h02
`define LRAC_R_DDLY_LO       8'hc0
`define LRAC_R_DDLY_HI       8'h25
`define LRAC_R_CDLY_LO_WIN   8'h71
`define LRAC_R_CDLY_HI       8'h0a
`define LRAC_TAP_MAX         10'h180
`define LRAC_STABLE_EDGES    4'hf
`define LRAC_SPI_BITS        5'h10
`define LRAC_SPI_CMD_BITS    5'h08
`endif

// File: verif/lrac_chk.sv
// port assertions for the receive aligner
`timescale 1ns/10ps
`include "lrac_map.vh"
module lrac_chk (
  // clock, reset, enable
  input wire       CLK_SYS_IN,
  input wire       RSTN_IN,
  input wire       CE_IN,
  // serial port
  input wire       SPI_CS_N_IN,
  input wire       SPI_SCLK_IN,
  input wire       SPI_SDI_IN,
  input wire       SPI_SDO_OUT,
  input wire       SPI_SDO_OE_N_OUT,
  // link side
  input wire       SRC_SYNC_DCLK_IN,
  input wire       PD_EARLY_IN,
  input wire       PD_LATE_IN,
  // delay settings and interrupt
  input wire [9:0] DATA_DELAY_OUT,
  input wire [9:0] CLK_DELAY_OUT,
  input wire [3:0] WINDOW_OUT,
  input wire       IRQ_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  // writes land while select is still low, so eight idle cycles are quiet
  sequence idle8;
    SPI_CS_N_IN [*8];
  endsequence
  reset_defaults_a: assert property (
    $rose(RSTN_IN) |-> ##[0:2] (DATA_DELAY_OUT == 10'h097 && CLK_DELAY_OUT == 10'h0a7
    && WINDOW_OUT == 4'h1)) else $error("delay defaults missing after reset");
  irq_quiet_a: assert property ($rose(RSTN_IN) |-> !IRQ_OUT [*8])
    else $error("irq raised before enable");
  tap_limit_a: assert property (
    DATA_DELAY_OUT <= `LRAC_TAP_MAX && CLK_DELAY_OUT <= `LRAC_TAP_MAX)
    else $error("tap beyond delay line end");
  oe_release_a: assert property (SPI_CS_N_IN [*5] |-> SPI_SDO_OE_N_OUT)
    else $error("sdo driven outside a frame");
  oe_start_a: assert property ($fell(SPI_SDO_OE_N_OUT) |-> !SPI_CS_N_IN)
    else $error("sdo enabled without select");
  sdo_hold_a: assert property (SPI_SCLK_IN [*6] |-> $stable(SPI_SDO_OUT))
    else $error("sdo moved while sclk high");
  window_hold_a: assert property (idle8 |=> $stable(WINDOW_OUT))
    else $error("window changed without a write");
  tap_shared_a: assert property (
    idle8 ##1 $changed(CLK_DELAY_OUT) |-> DATA_DELAY_OUT == CLK_DELAY_OUT)
    else $error("data and clock taps differ while aligning");
endmodule // lrac_chk

// File: verif/lrac_host.sv
// host-side model: link clock and phase detector levels
`timescale 1ns/10ps
module lrac_host (
  // control from the bench
  input  wire       run_in,
  input  wire [1:0] mode_in,
  // link outputs
  output reg        dclk_out,
  output wire       early_out,
  output wire       late_out
);
  // link clock stands still low between bursts
  initial dclk_out = 1'b0;
  always begin
    #100;
    dclk_out = run_in ? ~dclk_out : 1'b0;
  end
  assign early_out = mode_in[0];
  assign late_out  = mode_in[1];
endmodule // lrac_host

// File: verif/lrac_tb.sv
// self-checking bench for the receive aligner
`timescale 1ns/10ps
`include "lrac_map.vh"
`define CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  n_fail = n_fail + 1; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
  reg        clk, rst_n, cs_n, sclk, sdi, run, ce;
  reg  [1:0] mode;
  reg  [7:0] rd;
  wire       sdo, oe_n, dclk, early, late, irq;
  wire [9:0] ddly, cdly;
  wire [3:0] win;
  integer    n_fail, comparisons;
  always #12.5 clk = ~clk;
  lrac_top i_dut (.CLK_SYS_IN(clk), .RSTN_IN(rst_n), .CE_IN(ce), .SPI_CS_N_IN(cs_n),
    .SPI_SCLK_IN(sclk), .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_OE_N_OUT(oe_n),
    .SRC_SYNC_DCLK_IN(dclk), .PD_EARLY_IN(early), .PD_LATE_IN(late),
    .DATA_DELAY_OUT(ddly), .CLK_DELAY_OUT(cdly), .WINDOW_OUT(win), .IRQ_OUT(irq));
  lrac_host i_host (.run_in(run), .mode_in(mode), .dclk_out(dclk), .early_out(early),
    .late_out(late));
  // sclk half period of ten clocks keeps well above the sampler's minimum
  task spi(input rw, input [6:0] a, input [7:0] wd);
    reg [15:0] f;
    integer i;
    begin
      f = {rw, a, wd};
      @(negedge clk) cs_n = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        sdi = f[15-i];
        repeat (10) @(negedge clk);
        if (i > 7) rd[15-i] = sdo;
        sclk = 1'b1;
        repeat (10) @(negedge clk);
        sclk = 1'b0;
      end
      repeat (10) @(negedge clk);
      cs_n = 1'b1;
      repeat (10) @(negedge clk);
    end
  endtask
  task rchk(input [6:0] a, input [7:0] e);
    begin
      spi(1'b1, a, 8'h00);
      `CHK(rd, e)
    end
  endtask
  task edges(input [1:0] m, input integer n);
    begin
      @(negedge clk) mode = m;
      run = 1'b1;
      repeat (n) @(posedge dclk);
      @(negedge dclk) run = 1'b0;
      mode = 2'h0;
      repeat (8) @(negedge clk);
    end
  endtask
  task t_reset;
    begin
      rchk(7'h10, 8'h02);
      rchk(7'h11, 8'hc0);
      rchk(7'h12, 8'h25);
      rchk(7'h13, 8'h71);
      rchk(7'h14, 8'h0a);
      rchk(7'h1c, 8'h00);
      rchk(7'h21, 8'h00);
      rchk(7'h02, 8'h02);
      rchk(7'h03, 8'h00);
      rchk(7'h30, 8'h00);
    end
  endtask
  task t_fixed;
    begin
      spi(1'b0, 7'h11, 8'h40);
      spi(1'b0, 7'h12, 8'h30);
      `CHK(ddly, 10'h0c1)
      spi(1'b0, 7'h12, 8'hff);
      `CHK(ddly, 10'h180)
      spi(1'b0, 7'h13, 8'h25);
      spi(1'b0, 7'h14, 8'h0b);
      `CHK(cdly, 10'h0b2)
      `CHK(win, 4'h5)
      spi(1'b0, 7'h30, 8'hff);
      rchk(7'h30, 8'h00);
      spi(1'b0, 7'h11, 8'hc0);
      spi(1'b0, 7'h12, 8'h25);
      spi(1'b0, 7'h13, 8'h71);
      spi(1'b0, 7'h14, 8'h0a);
    end
  endtask
  // five early steps from 167, then quiet edges to lock at 172
  task t_lock;
    begin
      spi(1'b0, 7'h03, 8'h03);
      spi(1'b0, 7'h10, 8'h03);
      edges(2'h1, 5);
      edges(2'h0, 18);
      rchk(7'h21, 8'h09);
      rchk(7'h21, 8'h09);
      rchk(7'h1a, 8'h2b);
      rchk(7'h1b, 8'h00);
      rchk(7'h1c, 8'h2b);
      `CHK(cdly, 10'h0ac)
      `CHK(irq, 1'b1)
      spi(1'b0, 7'h02, 8'h00);
      edges(2'h1, 3);
      `CHK(cdly, 10'h0ac)
      spi(1'b0, 7'h02, 8'h02);
      // a frozen clock enable must ignore data clock edges
      ce = 1'b0;
      edges(2'h1, 3);
      ce = 1'b1;
      `CHK(cdly, 10'h0ac)
      rchk(7'h1c, 8'h2b);
    end
  endtask
  task t_lost;
    begin
      // lock interrupt off first, so only the lost event can raise the line
      spi(1'b0, 7'h03, 8'h02);
      `CHK(irq, 1'b0)
      edges(2'h3, 1);
      rchk(7'h21, 8'h06);
      rchk(7'h04, 8'h02);
      `CHK(irq, 1'b1)
      spi(1'b0, 7'h10, 8'h07);
      spi(1'b0, 7'h10, 8'h03);
      rchk(7'h21, 8'h04);
      spi(1'b0, 7'h03, 8'h00);
      rchk(7'h04, 8'h00);
      `CHK(irq, 1'b0)
      spi(1'b0, 7'h03, 8'h03);
      edges(2'h0, 18);
      rchk(7'h21, 8'h09);
      spi(1'b0, 7'h10, 8'h01);
      edges(2'h3, 1);
      rchk(7'h21, 8'h02);
      spi(1'b0, 7'h10, 8'h02);
      `CHK(ddly, 10'h097)
      `CHK(cdly, 10'h0a7)
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d, failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    {clk, rst_n, sclk, sdi, run, mode} = 7'h00;
    cs_n = 1'b1;
    ce = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(ddly, 10'h097)
    t_reset;
    t_fixed;
    t_lock;
    t_lost;
    final_report;
  end
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    final_report;
  end
endmodule // tb
bind lrac_top lrac_chk i_chk (.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .CE_IN(CE_IN),
  .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_SCLK_IN(SPI_SCLK_IN), .SPI_SDI_IN(SPI_SDI_IN),
  .SPI_SDO_OUT(SPI_SDO_OUT), .SPI_SDO_OE_N_OUT(SPI_SDO_OE_N_OUT),
  .SRC_SYNC_DCLK_IN(SRC_SYNC_DCLK_IN), .PD_EARLY_IN(PD_EARLY_IN), .PD_LATE_IN(PD_LATE_IN),
  .DATA_DELAY_OUT(DATA_DELAY_OUT), .CLK_DELAY_OUT(CLK_DELAY_OUT),
  .WINDOW_OUT(WINDOW_OUT), .IRQ_OUT(IRQ_OUT));
